// ### gpio_port_defs.svh
// register offsets, field positions, reset values for the gpio port block
`ifndef GPIO_PORT_DEFS_SVH
`define GPIO_PORT_DEFS_SVH

// ----------------------------------------
// memory-mapped control register addresses
// ----------------------------------------
`define ADDR_GROUP_H_DIRECTION 16'h7fa3
`define ADDR_GROUP_H_PIN_INPUT 16'h7fa4
`define ADDR_GROUP_H_PIN_OUTPUT 16'h7fa5
`define ADDR_GROUP_OWNER_SELECT 16'h7fa9
`define ADDR_GROUP_H_BUFFER_TYPE 16'h7faa
`define ADDR_MISC_PIN_BUFFER_TYPE 16'h7fac
`define ADDR_SFR_GPIO_DIRECTION 16'h7fad

// ----------------------------------------
// special function register address
// ----------------------------------------
`define SFR_ADDR_GPIO_DATA 8'h80
`define SFR_BIT_INDEX_W 3

// ----------------------------------------
// field positions
// ----------------------------------------
`define OWNER_BIT_GROUP_H 1
`define OWNER_BIT_GROUP_G 0
`define MISC_BIT_GPIO_PIN_7 1
`define MISC_BIT_OUTPUT_PIN_0 0
`define NIBBLE_MASK 8'h0f
`define PAIR_MASK 8'h03

// ----------------------------------------
// reset values
// ----------------------------------------
`define RESET_VALUE 8'h00

`endif

// ### gpio_port_pkg.sv
// types shared by the gpio port block
package gpio_port_pkg;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mmcr_req_s;

	typedef struct packed {
		logic byte_wr;
		logic bit_wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic bit_value;
	} sfr_req_s;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} pin_drive_s;

endpackage

// ### gpio_port.sv
// gpio group h, ownership select, buffer types and sfr gpio port
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defs.svh"

module gpio_port
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire gpio_port_pkg::mmcr_req_s mmcr_req_i,
	output logic [7:0] mmcr_rdata_o,
	input wire gpio_port_pkg::sfr_req_s sfr_req_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic [3:0] host_dir_i,
	input wire logic [3:0] host_out_i,
	input wire logic [3:0] host_gpio_h_i,
	output logic [3:0] host_gpio_h_o,
	output logic [3:0] host_gpio_h_oe_o,
	output logic group_g_host_owned_o,
	input wire logic [3:0] sfr_gpio_i,
	output logic [3:0] sfr_gpio_o,
	output logic [3:0] sfr_gpio_oe_o,
	input wire logic gpio_pin_7_out_i,
	input wire logic gpio_pin_7_dir_i,
	output logic gpio_pin_7_o,
	output logic gpio_pin_7_oe_o,
	input wire logic output_pin_0_out_i,
	output logic output_pin_0_o,
	output logic output_pin_0_oe_o
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// open-drain drives only low; push-pull drives both levels
	function automatic gpio_port_pkg::pin_drive_s drive_pins(input logic [3:0] dir,
		input logic [3:0] val, input logic [3:0] open_drain);
		gpio_port_pkg::pin_drive_s d;
		d.out = val & ~open_drain;
		d.oe = dir & (~open_drain | ~val);
		return d;
	endfunction

	function automatic logic [7:0] low_nibble(input logic [7:0] v);
		return v & `NIBBLE_MASK;
	endfunction

	// ----------------------------------------
	// register state
	// ----------------------------------------
	// register access never looks at ownership, so either owner can program
	function automatic logic mmcr_write_hit(input gpio_port_pkg::mmcr_req_s req,
		input logic [15:0] reg_addr);
		return req.wr && req.addr == reg_addr;
	endfunction

	logic [7:0] group_h_direction;
	logic [7:0] next_group_h_direction;

	always_comb
	begin
		next_group_h_direction = group_h_direction;
		if (mmcr_write_hit(mmcr_req_i, `ADDR_GROUP_H_DIRECTION))
		begin
			next_group_h_direction = low_nibble(mmcr_req_i.wdata);
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			group_h_direction <= `RESET_VALUE;
		end
		else
		begin
			group_h_direction <= next_group_h_direction;
		end
	end

	logic [7:0] group_h_pin_output;
	logic [7:0] next_group_h_pin_output;

	always_comb
	begin
		next_group_h_pin_output = group_h_pin_output;
		if (mmcr_write_hit(mmcr_req_i, `ADDR_GROUP_H_PIN_OUTPUT))
		begin
			next_group_h_pin_output = low_nibble(mmcr_req_i.wdata);
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			group_h_pin_output <= `RESET_VALUE;
		end
		else
		begin
			group_h_pin_output <= next_group_h_pin_output;
		end
	end

	logic [7:0] group_owner_select;
	logic [7:0] next_group_owner_select;

	always_comb
	begin
		next_group_owner_select = group_owner_select;
		if (mmcr_write_hit(mmcr_req_i, `ADDR_GROUP_OWNER_SELECT))
		begin
			next_group_owner_select = mmcr_req_i.wdata & `PAIR_MASK;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			group_owner_select <= `RESET_VALUE;
		end
		else
		begin
			group_owner_select <= next_group_owner_select;
		end
	end

	logic [7:0] group_h_buffer_type;
	logic [7:0] next_group_h_buffer_type;

	always_comb
	begin
		next_group_h_buffer_type = group_h_buffer_type;
		if (mmcr_write_hit(mmcr_req_i, `ADDR_GROUP_H_BUFFER_TYPE))
		begin
			next_group_h_buffer_type = low_nibble(mmcr_req_i.wdata);
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			group_h_buffer_type <= `RESET_VALUE;
		end
		else
		begin
			group_h_buffer_type <= next_group_h_buffer_type;
		end
	end

	logic [7:0] misc_pin_buffer_type;
	logic [7:0] next_misc_pin_buffer_type;

	always_comb
	begin
		next_misc_pin_buffer_type = misc_pin_buffer_type;
		if (mmcr_write_hit(mmcr_req_i, `ADDR_MISC_PIN_BUFFER_TYPE))
		begin
			next_misc_pin_buffer_type = mmcr_req_i.wdata & `PAIR_MASK;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			misc_pin_buffer_type <= `RESET_VALUE;
		end
		else
		begin
			misc_pin_buffer_type <= next_misc_pin_buffer_type;
		end
	end

	logic [7:0] sfr_gpio_direction;
	logic [7:0] next_sfr_gpio_direction;

	always_comb
	begin
		next_sfr_gpio_direction = sfr_gpio_direction;
		if (mmcr_write_hit(mmcr_req_i, `ADDR_SFR_GPIO_DIRECTION))
		begin
			next_sfr_gpio_direction = low_nibble(mmcr_req_i.wdata);
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			sfr_gpio_direction <= `RESET_VALUE;
		end
		else
		begin
			sfr_gpio_direction <= next_sfr_gpio_direction;
		end
	end

	logic [7:0] sfr_gpio_data;
	logic [7:0] next_sfr_gpio_data;
	logic sfr_bit_hit;
	logic [`SFR_BIT_INDEX_W-1:0] sfr_bit_index;

	// bit address = register address + bit index, only bits 3..0 exist
	assign sfr_bit_hit = sfr_req_i.bit_wr && sfr_req_i.addr >= `SFR_ADDR_GPIO_DATA
		&& sfr_req_i.addr <= `SFR_ADDR_GPIO_DATA + 8'h03;
	assign sfr_bit_index = sfr_req_i.addr[`SFR_BIT_INDEX_W-1:0];

	// a bit operation in the same cycle as a byte write wins
	always_comb
	begin
		next_sfr_gpio_data = sfr_gpio_data;
		if (sfr_req_i.byte_wr && sfr_req_i.addr == `SFR_ADDR_GPIO_DATA)
		begin
			next_sfr_gpio_data = low_nibble(sfr_req_i.wdata);
		end
		if (sfr_bit_hit)
		begin
			next_sfr_gpio_data[sfr_bit_index] = sfr_req_i.bit_value;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			sfr_gpio_data <= `RESET_VALUE;
		end
		else
		begin
			sfr_gpio_data <= next_sfr_gpio_data;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [7:0] next_mmcr_rdata;
	logic [7:0] next_sfr_rdata;

	always_comb
	begin
		next_mmcr_rdata = 8'h00;
		if (mmcr_req_i.rd)
		begin
			unique case (mmcr_req_i.addr)
				`ADDR_GROUP_H_DIRECTION: next_mmcr_rdata = group_h_direction;
				`ADDR_GROUP_H_PIN_INPUT: next_mmcr_rdata = {4'h0, host_gpio_h_i};
				`ADDR_GROUP_H_PIN_OUTPUT: next_mmcr_rdata = group_h_pin_output;
				`ADDR_GROUP_OWNER_SELECT: next_mmcr_rdata = group_owner_select;
				`ADDR_GROUP_H_BUFFER_TYPE: next_mmcr_rdata = group_h_buffer_type;
				`ADDR_MISC_PIN_BUFFER_TYPE: next_mmcr_rdata = misc_pin_buffer_type;
				`ADDR_SFR_GPIO_DIRECTION: next_mmcr_rdata = sfr_gpio_direction;
				default: next_mmcr_rdata = 8'h00;
			endcase
		end
		// data register returns latch contents, as bit ops read-modify-write it
		next_sfr_rdata = (sfr_req_i.addr == `SFR_ADDR_GPIO_DATA) ? sfr_gpio_data : 8'h00;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			mmcr_rdata_o <= 8'h00;
			sfr_rdata_o <= 8'h00;
		end
		else
		begin
			mmcr_rdata_o <= next_mmcr_rdata;
			sfr_rdata_o <= next_sfr_rdata;
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	logic host_owns_h;
	logic [3:0] h_dir;
	logic [3:0] h_val;
	gpio_port_pkg::pin_drive_s h_drive;
	gpio_port_pkg::pin_drive_s s_drive;
	gpio_port_pkg::pin_drive_s m_drive;

	assign host_owns_h = group_owner_select[`OWNER_BIT_GROUP_H];
	assign h_dir = host_owns_h ? host_dir_i : group_h_direction[3:0];
	assign h_val = host_owns_h ? host_out_i : group_h_pin_output[3:0];
	assign h_drive = drive_pins(h_dir, h_val, group_h_buffer_type[3:0]);
	assign s_drive = drive_pins(sfr_gpio_direction[3:0], sfr_gpio_data[3:0], 4'h0);
	assign m_drive = drive_pins({2'b00, gpio_pin_7_dir_i, 1'b1},
		{2'b00, gpio_pin_7_out_i, output_pin_0_out_i},
		{2'b00, misc_pin_buffer_type[`MISC_BIT_GPIO_PIN_7],
		misc_pin_buffer_type[`MISC_BIT_OUTPUT_PIN_0]});

	assign host_gpio_h_o = h_drive.out;
	assign host_gpio_h_oe_o = h_drive.oe;
	assign group_g_host_owned_o = group_owner_select[`OWNER_BIT_GROUP_G];
	assign sfr_gpio_o = s_drive.out;
	assign sfr_gpio_oe_o = s_drive.oe;
	assign gpio_pin_7_o = m_drive.out[1];
	assign gpio_pin_7_oe_o = m_drive.oe[1];
	assign output_pin_0_o = m_drive.out[0];
	assign output_pin_0_oe_o = m_drive.oe[0];

endmodule
`default_nettype wire

// ### gpio_port_assertions.sv
// assertion checker for the gpio port block, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module gpio_port_assertions
(
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire gpio_port_pkg::mmcr_req_s mmcr_req_i,
	input wire logic [7:0] mmcr_rdata_o,
	input wire gpio_port_pkg::sfr_req_s sfr_req_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic [3:0] host_gpio_h_i,
	input wire logic [3:0] host_gpio_h_oe_o,
	input wire logic group_g_host_owned_o,
	input wire logic [3:0] sfr_gpio_oe_o,
	input wire logic gpio_pin_7_dir_i,
	input wire logic gpio_pin_7_oe_o,
	input wire logic output_pin_0_out_i,
	input wire logic output_pin_0_o,
	input wire logic output_pin_0_oe_o
);
	// ----------------
	// checks
	// ----------------
	logic [3:0] dir_shadow;
	wire dir_wr = mmcr_req_i.wr && mmcr_req_i.addr == 16'h7fa3;
	// shadow of the last direction write, predicts the read-back
	always_ff @(posedge sys_clk_i)
		dir_shadow <= sys_rst_i ? 4'h0 : dir_wr ? mmcr_req_i.wdata[3:0] : dir_shadow;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_reserved_zero: assert property (mmcr_rdata_o[7:4] == 4'h0 && sfr_rdata_o[7:4] == 4'h0)
		else $error("reserved bits read set");
	a_input_read: assert property (mmcr_req_i.rd && mmcr_req_i.addr == 16'h7fa4
		|=> mmcr_rdata_o == {4'h0, $past(host_gpio_h_i)}) else $error("pin level read wrong");
	a_dir_readback: assert property (mmcr_req_i.rd && !mmcr_req_i.wr && mmcr_req_i.addr == 16'h7fa3
		|=> mmcr_rdata_o == {4'h0, $past(dir_shadow)}) else $error("direction read wrong");
	a_owner_level: assert property (mmcr_req_i.wr && mmcr_req_i.addr == 16'h7fa9
		|=> group_g_host_owned_o == $past(mmcr_req_i.wdata[0])) else $error("owner bit wrong");
	a_reset_idle: assert property ($past(sys_rst_i) |-> !group_g_host_owned_o
		&& host_gpio_h_oe_o == 4'h0 && sfr_gpio_oe_o == 4'h0) else $error("pins driven after reset");
	a_pin7_release: assert property (!gpio_pin_7_dir_i |-> !gpio_pin_7_oe_o)
		else $error("input pin driven");
	a_pin0_low: assert property (!output_pin_0_out_i |-> output_pin_0_oe_o && !output_pin_0_o)
		else $error("low level not driven");
	a_sfr_bit: assert property (sfr_req_i.bit_wr && sfr_req_i.addr[7:2] == 6'h20
		##1 !sfr_req_i.bit_wr && !sfr_req_i.byte_wr
		##1 sfr_req_i.addr == 8'h80 && !sfr_req_i.bit_wr && !sfr_req_i.byte_wr
		|=> sfr_rdata_o[$past(sfr_req_i.addr[1:0], 3)] == $past(sfr_req_i.bit_value, 3))
		else $error("bit write lost");
	c_owner: cover property (mmcr_req_i.wr && mmcr_req_i.addr == 16'h7fa9 && mmcr_req_i.wdata[1]);
	c_bit_clear: cover property (sfr_req_i.bit_wr && !sfr_req_i.bit_value);
	c_open_drain: cover property (output_pin_0_out_i && !output_pin_0_oe_o);
endmodule
bind gpio_port gpio_port_assertions gpio_port_assertions_i (.*);
`default_nettype wire

// ### board_pins.sv
// board-side model of four general-purpose pins
`timescale 1ns/1ps
`default_nettype none
module board_pins
(
	input wire logic [3:0] drv_i,
	input wire logic [3:0] oe_i,
	input wire logic [3:0] ext_val_i,
	input wire logic [3:0] ext_en_i,
	output logic [3:0] level_o
);
	// released lines not driven externally go to the pull-up, never keep the last value
	assign level_o = (oe_i & drv_i) | (~oe_i & ((ext_en_i & ext_val_i) | ~ext_en_i));
endmodule
`default_nettype wire

// ### gpio_port_test.sv
// self-checking bench for the gpio port block
`timescale 1ns/1ps
`default_nettype none
module gpio_port_test;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	gpio_port_pkg::mmcr_req_s mmcr_req_i = '0;
	gpio_port_pkg::sfr_req_s sfr_req_i = '0;
	logic [3:0] host_dir_i = 4'h0, host_out_i = 4'h0, ext_en = 4'h0, ext_val = 4'h0;
	logic gpio_pin_7_out_i = 1'b1, gpio_pin_7_dir_i = 1'b1, output_pin_0_out_i = 1'b1;
	logic [7:0] mmcr_rdata_o, sfr_rdata_o;
	logic [3:0] host_gpio_h_i, host_gpio_h_o, host_gpio_h_oe_o, sfr_gpio_i, sfr_gpio_o, sfr_gpio_oe_o;
	logic group_g_host_owned_o, gpio_pin_7_o, gpio_pin_7_oe_o, output_pin_0_o, output_pin_0_oe_o;
	int n_errors = 0, checked = 0, cycles = 0;
	logic [15:0] regs [7] = '{16'h7fa3, 16'h7fa5, 16'h7fa9, 16'h7faa, 16'h7fac, 16'h7fad, 16'h7fa6};
	logic [7:0] masks [7] = '{8'h0f, 8'h0f, 8'h03, 8'h0f, 8'h03, 8'h0f, 8'h00};
	gpio_port gpio_port_i (.*);
	board_pins h_pins_i (.drv_i(host_gpio_h_o), .oe_i(host_gpio_h_oe_o), .ext_val_i(ext_val),
		.ext_en_i(ext_en), .level_o(host_gpio_h_i));
	board_pins s_pins_i (.drv_i(sfr_gpio_o), .oe_i(sfr_gpio_oe_o), .ext_val_i(4'h0),
		.ext_en_i(4'h0), .level_o(sfr_gpio_i));
	// ----------------
	// access tasks
	// ----------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic mw(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		mmcr_req_i = {1'b1, 1'b0, a, d};
		@(negedge sys_clk_i);
		mmcr_req_i = '0;
	endtask
	task automatic mr(input logic [15:0] a, input logic [7:0] exp);
		@(negedge sys_clk_i);
		mmcr_req_i = {1'b0, 1'b1, a, 8'h00};
		@(negedge sys_clk_i);
		check(mmcr_rdata_o, exp);
		mmcr_req_i = '0;
	endtask
	task automatic sw(input logic by, input logic bi, input logic [7:0] a, d, input logic v);
		@(negedge sys_clk_i);
		sfr_req_i = {by, bi, a, d, v};
		@(negedge sys_clk_i);
		sfr_req_i = '0;
	endtask
	task automatic sr(input logic [7:0] exp);
		@(negedge sys_clk_i);
		sfr_req_i = {2'b00, 8'h80, 8'h00, 1'b0};
		@(negedge sys_clk_i);
		check(sfr_rdata_o, exp);
		sfr_req_i = '0;
	endtask
	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
		forever #50 sys_clk_i = ~sys_clk_i;
	// hang guard, the sequence needs under a hundred cycles
	always @(posedge sys_clk_i)
		if (++cycles == 2000)
		begin
			n_errors++;
			finish_test();
		end
	initial
	begin
		repeat (4) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		for (int i = 0; i < 7; i++)
			mr(regs[i], 8'h00);
		mr(16'h7fa4, 8'h0f);
		sr(8'h00);
		for (int i = 0; i < 7; i++)
		begin
			mw(regs[i], 8'hff);
			mr(regs[i], masks[i]);
		end
		check({host_gpio_h_oe_o, 3'h0, group_g_host_owned_o}, 8'h01);
		mw(16'h7faa, 8'h00);
		host_dir_i = 4'hf;
		host_out_i = 4'h3;
		@(negedge sys_clk_i);
		check({host_gpio_h_oe_o, host_gpio_h_o}, 8'hf3);
		mw(16'h7fa9, 8'h00);
		mw(16'h7fa5, 8'h0a);
		check({host_gpio_h_oe_o, host_gpio_h_o}, 8'hfa);
		mw(16'h7faa, 8'h0f);
		check({host_gpio_h_oe_o, host_gpio_h_o}, 8'h50);
		mr(16'h7fa4, 8'h0a);
		mw(16'h7fa3, 8'h00);
		ext_en = 4'hf;
		ext_val = 4'h5;
		mr(16'h7fa4, 8'h05);
		check({4'h0, host_gpio_h_oe_o}, 8'h00);
		output_pin_0_out_i = 1'b0;
		@(negedge sys_clk_i);
		check({6'h0, gpio_pin_7_oe_o, output_pin_0_oe_o}, 8'h01);
		mw(16'h7fac, 8'h00);
		output_pin_0_out_i = 1'b1;
		@(negedge sys_clk_i);
		check({4'h0, gpio_pin_7_oe_o, gpio_pin_7_o, output_pin_0_oe_o, output_pin_0_o}, 8'h0f);
		gpio_pin_7_dir_i = 1'b0;
		sw(1'b1, 1'b0, 8'h80, 8'hff, 1'b0);
		sr(8'h0f);
		check({sfr_gpio_oe_o, sfr_gpio_o}, 8'hff);
		for (int i = 0; i < 4; i++)
			sw(1'b0, 1'b1, 8'h80 + 8'(i), 8'h00, i[0]);
		sr(8'h0a);
		mw(16'h7fad, 8'h00);
		check({sfr_gpio_oe_o, 4'h0}, 8'h00);
		sys_rst_i = 1'b1;
		@(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		mr(16'h7fa5, 8'h00);
		sr(8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
